// >>> adcdmx_device.sv
`timescale 1ns/100ps
`include "adcdmx_params.svh"
module adcdmx_device
  import adcdmx_pkg::*;
#(
  parameter int WORD_W = `ADCDMX_WORD_W
) (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Converter sample input and hardware pins
  input wire logic [WORD_W-1:0] sample_in,
  input wire logic demux_ratio_select,
  // Link to the capture logic
  adcdmx_link_if.device link,
  // Current ratio in force
  output logic dual_mode
);
  localparam int FW = `ADCDMX_SER_FRAME_W;
  localparam int DW = `ADCDMX_SER_DATA_W;
  logic [3:0] por_cnt_q;
  logic por_done;
  logic rs_q1, rs_q2;
  logic ck_q1, ck_q2, ck_q3;
  logic ld_q1, ld_q2, di_q1, di_q2, en_q1, en_q2;
  logic [FW-1:0] shreg_q;
  logic [4:0] bit_cnt_q;
  logic [DW-1:0] state_reg_q;
  adcdmx_ser_state_t ser_st_q;
  logic ratio_sel;
  logic run;
  logic phase_q;
  logic [WORD_W-1:0] hold_q;
  logic [WORD_W-1:0] pa_q, pb_q;
  logic par_a_q, par_b_q, strobe_q;
  logic shift_edge;

  // Power-up reset stretch, counted from release of the external reset rst_b
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt_q <= 4'h0;
    end else if (clk_en && por_cnt_q != `ADCDMX_POR_CYCLES) begin
      por_cnt_q <= por_cnt_q + 4'h1;
    end
  end
  assign por_done = (por_cnt_q == `ADCDMX_POR_CYCLES);

  // Synchronise resync request and serial pins
  // The pins are levels from slow logic; two flops on each keep a
  // late change from being seen differently by two consumers.
  // Data and shift clock share the same delay, so their relative
  // timing at the shifter matches the timing on the wires.
  // The serial reset pin is not synchronised: it acts asynchronously.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rs_q1 <= 1'b1;
      rs_q2 <= 1'b1;
      {ck_q1, ck_q2, ck_q3} <= 3'b000;
      {ld_q1, ld_q2, di_q1, di_q2} <= 4'b1100;
      {en_q1, en_q2} <= 2'b11;
    end else if (clk_en) begin
      rs_q1 <= link.resync_low;
      rs_q2 <= rs_q1;
      ck_q1 <= link.serial_shift_clk;
      ck_q2 <= ck_q1;
      ck_q3 <= ck_q2;
      ld_q1 <= link.serial_load_low;
      ld_q2 <= ld_q1;
      di_q1 <= link.serial_data_in;
      di_q2 <= di_q1;
      en_q1 <= link.serial_port_enable_low;
      en_q2 <= en_q1;
    end
  end
  assign shift_edge = ck_q2 && !ck_q3;

  // Serial shifter: write-only, no readback path
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg_q <= '0;
      bit_cnt_q <= 5'h00;
      ser_st_q <= ADCDMX_ST_IDLE;
    end else if (clk_en) begin
      case (ser_st_q)
        ADCDMX_ST_IDLE: begin
          bit_cnt_q <= 5'h00;
          if (!en_q2 && !ld_q2) begin
            ser_st_q <= ADCDMX_ST_SHIFT;
          end
        end
        ADCDMX_ST_SHIFT: begin
          if (en_q2 || ld_q2) begin
            ser_st_q <= ADCDMX_ST_IDLE;
          end else if (shift_edge) begin
            shreg_q <= {shreg_q[FW-2:0], di_q2};
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == 5'(FW - 1)) begin
              ser_st_q <= ADCDMX_ST_DONE;
            end
          end
        end
        ADCDMX_ST_DONE: begin
          if (ld_q2) begin
            ser_st_q <= ADCDMX_ST_IDLE;
          end
        end
        default: begin
          ser_st_q <= ADCDMX_ST_IDLE;
        end
      endcase
    end
  end

  // Settings: async serial reset returns defaults; write-only
  always_ff @(posedge ref_clk or negedge rst_b or negedge
      link.serial_reset_low) begin
    if (!rst_b || !link.serial_reset_low) begin
      state_reg_q <= `ADCDMX_STATE_RESET;
    end else if (clk_en && en_q2) begin
      state_reg_q <= `ADCDMX_STATE_RESET;
    end else if (clk_en && ser_st_q == ADCDMX_ST_SHIFT && shift_edge &&
        bit_cnt_q == 5'(FW - 1) &&
        shreg_q[FW-2:DW-1] == `ADCDMX_ADDR_STATE) begin
      state_reg_q <= {shreg_q[DW-2:0], di_q2};
    end
  end

  // Ratio source: serial setting overrides pin when enabled
  assign ratio_sel = !en_q2 ? state_reg_q[`ADCDMX_STATE_RS_BIT]
                            : demux_ratio_select;
  assign run = por_done && rs_q2;

  // Sampling, demux and strobe generation
  // Dual mode holds the earlier sample for one clock, so both ports
  // change on the same edge and the strobe toggles once per pair.
  // Single mode leaves the second port and its parity frozen.
  // Parity is even: word bits and parity bit XOR to zero.
  // While not running the strobe parks low and words hold, so the
  // receiver sees at most the one falling edge as a resync begins.
  // The ratio in force is registered so a user can see it settle.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 1'b0;
      hold_q <= '0;
      pa_q <= '0;
      pb_q <= '0;
      par_a_q <= 1'b0;
      par_b_q <= 1'b0;
      strobe_q <= 1'b0;
      dual_mode <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        phase_q <= 1'b0;
        strobe_q <= 1'b0;
        dual_mode <= ratio_sel;
      end else if (ratio_sel == ADCDMX_SINGLE) begin
        pa_q <= sample_in;
        par_a_q <= ^sample_in;
        strobe_q <= !strobe_q;
        phase_q <= 1'b0;
        dual_mode <= 1'b0;
      end else if (!phase_q) begin
        hold_q <= sample_in;
        phase_q <= 1'b1;
        dual_mode <= 1'b1;
      end else begin
        pa_q <= hold_q;
        pb_q <= sample_in;
        par_a_q <= ^hold_q;
        par_b_q <= ^sample_in;
        strobe_q <= !strobe_q;
        phase_q <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops
  assign link.first_port_word = pa_q;
  assign link.second_port_word = pb_q;
  assign link.first_port_parity = par_a_q;
  assign link.second_port_parity = par_b_q;
  assign link.shared_output_strobe = strobe_q;
endmodule : adcdmx_device

// >>> adcdmx_params.svh
`ifndef ADCDMX_PARAMS_SVH
`define ADCDMX_PARAMS_SVH
// Output word width
`define ADCDMX_WORD_W 12
// Serial frame: 4 address bits then 16 data bits, MSB first
`define ADCDMX_SER_ADDR_W 4
`define ADCDMX_SER_DATA_W 16
`define ADCDMX_SER_FRAME_W 20
// Serial state register address and field positions
`define ADCDMX_ADDR_STATE 4'h1
`define ADCDMX_STATE_RS_BIT 0
// Reset value of the state register (two-port mode)
`define ADCDMX_STATE_RESET 16'h0001
// Power-up reset stretch in sampling clocks
`define ADCDMX_POR_CYCLES 4'h4
`endif

// >>> adcdmx_pkg.sv
package adcdmx_pkg;
  typedef enum logic [0:0] {
    ADCDMX_SINGLE = 1'b0,
    ADCDMX_DUAL = 1'b1
  } adcdmx_ratio_t;
  typedef enum logic [1:0] {
    ADCDMX_ST_IDLE = 2'b00,
    ADCDMX_ST_SHIFT = 2'b01,
    ADCDMX_ST_DONE = 2'b10
  } adcdmx_ser_state_t;
endpackage : adcdmx_pkg

// >>> adcdmx_link_if.sv
`timescale 1ns/100ps
interface adcdmx_link_if;
  logic [11:0] first_port_word;
  logic [11:0] second_port_word;
  logic first_port_parity;
  logic second_port_parity;
  logic shared_output_strobe;
  logic resync_low;
  logic serial_port_enable_low;
  logic serial_shift_clk;
  logic serial_data_in;
  logic serial_load_low;
  logic serial_reset_low;
  modport device (
    output first_port_word, second_port_word, first_port_parity,
    output second_port_parity, shared_output_strobe,
    input resync_low, serial_port_enable_low, serial_shift_clk,
    input serial_data_in, serial_load_low, serial_reset_low
  );
  modport capture (
    input first_port_word, second_port_word, first_port_parity,
    input second_port_parity, shared_output_strobe,
    output resync_low, serial_port_enable_low, serial_shift_clk,
    output serial_data_in, serial_load_low, serial_reset_low
  );
endinterface : adcdmx_link_if

// >>> adcdmx_capture.sv
`timescale 1ns/100ps
`include "adcdmx_params.svh"
module adcdmx_capture
  import adcdmx_pkg::*;
#(
  parameter int WORD_W = `ADCDMX_WORD_W,
  parameter int FW = `ADCDMX_SER_FRAME_W
) (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Link to the converter
  adcdmx_link_if.capture link,
  // User side: control
  input wire logic resync_req,
  input wire logic serial_enable,
  input wire logic serial_reset_req,
  input wire logic cfg_start,
  input wire logic [FW-1:0] cfg_frame,
  output logic cfg_busy,
  // User side: captured words
  output logic [WORD_W-1:0] cap_first,
  output logic [WORD_W-1:0] cap_second,
  output logic cap_parity_ok,
  output logic cap_valid
);
  logic strobe_q;
  logic [FW-1:0] frame_q;
  logic [4:0] cnt_q;
  logic [1:0] div_q;
  logic sck_q, sld_q, sdi_q;

  // Capture on both strobe edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q <= 1'b0;
      cap_first <= '0;
      cap_second <= '0;
      cap_parity_ok <= 1'b0;
      cap_valid <= 1'b0;
    end else if (clk_en) begin
      strobe_q <= link.shared_output_strobe;
      cap_valid <= 1'b0;
      if (strobe_q != link.shared_output_strobe) begin
        cap_first <= link.first_port_word;
        cap_second <= link.second_port_word;
        cap_parity_ok <= (^link.first_port_word == link.first_port_parity);
        cap_valid <= 1'b1;
      end
    end
  end

  // Serial writer: data set while clock low, rises mid-bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= '0;
      cnt_q <= 5'h00;
      div_q <= 2'b00;
      sck_q <= 1'b0;
      sld_q <= 1'b1;
      sdi_q <= 1'b0;
    end else if (clk_en) begin
      if (sld_q) begin
        if (cfg_start && serial_enable) begin
          frame_q <= cfg_frame;
          cnt_q <= 5'(FW);
          div_q <= 2'b00;
          sld_q <= 1'b0;
        end
      end else begin
        div_q <= div_q + 2'b01;
        if (div_q == 2'b00) begin
          if (cnt_q == 5'h00) begin
            sld_q <= 1'b1;
          end else begin
            sdi_q <= frame_q[FW-1];
            frame_q <= {frame_q[FW-2:0], 1'b0};
            cnt_q <= cnt_q - 5'h01;
          end
        end else if (div_q == 2'b01 && cnt_q != 5'(FW)) begin
          sck_q <= 1'b0;
        end else if (div_q == 2'b10) begin
          sck_q <= 1'b1;
        end else if (div_q == 2'b11) begin
          sck_q <= 1'b0;
        end
      end
    end
  end

  // Link drive
  assign link.serial_shift_clk = sck_q;
  assign link.serial_load_low = sld_q;
  assign link.serial_data_in = sdi_q;
  assign link.serial_port_enable_low = !serial_enable;
  assign link.serial_reset_low = !serial_reset_req;
  assign link.resync_low = !resync_req;
  assign cfg_busy = !sld_q;
endmodule : adcdmx_capture

// >>> adcdmx_link_properties.sv
`timescale 1ns/100ps
module adcdmx_link_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Link signals
  input wire logic [11:0] first_port_word,
  input wire logic [11:0] second_port_word,
  input wire logic first_port_parity,
  input wire logic second_port_parity,
  input wire logic shared_output_strobe,
  input wire logic resync_low,
  input wire logic serial_load_low,
  input wire logic serial_shift_clk
);
  localparam int LOAD_LEN = 81;
  logic [6:0] low_q;
  logic [4:0] rise_q;
  logic [3:0] run_q;
  logic sck_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Load-low cycles and shift rises within one frame
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_q <= 7'h00;
      rise_q <= 5'h00;
    end else if (serial_load_low) begin
      low_q <= 7'h00;
      rise_q <= 5'h00;
    end else begin
      low_q <= low_q + 7'h01;
      rise_q <= rise_q + 5'(serial_shift_clk && !sck_q);
    end
  end
  // Settled run time since resync released
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 4'h0;
      sck_q <= 1'b0;
    end else if (!resync_low) begin
      run_q <= 4'h0;
      sck_q <= 1'b0;
    end else begin
      run_q <= (run_q == 4'hf) ? run_q : run_q + 4'h1;
      sck_q <= serial_shift_clk;
    end
  end
  property p_par_a;
    first_port_parity == ^first_port_word;
  endproperty
  a_par_a: assert property (p_par_a) else $error("port one parity");
  property p_par_b;
    second_port_parity == ^second_port_word;
  endproperty
  a_par_b: assert property (p_par_b) else $error("port two parity");
  property p_a_edge;
    $changed(first_port_word) |-> $changed(shared_output_strobe);
  endproperty
  a_a_edge: assert property (p_a_edge) else $error("word off strobe");
  property p_b_edge;
    $changed(second_port_word) |-> $changed(shared_output_strobe);
  endproperty
  a_b_edge: assert property (p_b_edge) else $error("port two off");
  property p_rate;
    run_q == 4'hf && $stable(shared_output_strobe) |=>
      $changed(shared_output_strobe);
  endproperty
  a_rate: assert property (p_rate) else $error("strobe rate");
  property p_resync;
    !resync_low [*5] |-> !shared_output_strobe && $stable(first_port_word);
  endproperty
  a_resync: assert property (p_resync) else $error("resync");
  property p_sck_idle;
    serial_load_low |-> !serial_shift_clk;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("shift idle");
  property p_load_len;
    $rose(serial_load_low) |-> low_q == LOAD_LEN && rise_q == 5'h14;
  endproperty
  a_load_len: assert property (p_load_len) else $error("frame");
  c_dual: cover property ($changed(second_port_word));
  c_resync: cover property ($rose(resync_low));
  c_frame: cover property ($rose(serial_load_low));
endmodule : adcdmx_link_properties

// >>> adc_demux_output_and_serial_port_tb.sv
`timescale 1ns/100ps
module adc_demux_output_and_serial_port_tb;
  import adcdmx_pkg::*;
  logic ref_clk, rst_b, clk_en, pin, dual_mode, rsy, ser_en, ser_rst;
  logic cfg_start, cfg_busy, par_ok, cap_valid;
  logic [11:0] sample_in, cap_a, cap_b, wa, wb, a0;
  logic [19:0] cfg_frame;
  int err_total, n_checks, n;
  adcdmx_link_if link();
  adcdmx_device i_adcdmx_device (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(clk_en), .sample_in(sample_in), .demux_ratio_select(pin),
    .link(link), .dual_mode(dual_mode));
  adcdmx_capture i_adcdmx_capture (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(clk_en), .link(link), .resync_req(rsy), .serial_enable(ser_en),
    .serial_reset_req(ser_rst), .cfg_start(cfg_start),
    .cfg_frame(cfg_frame), .cfg_busy(cfg_busy), .cap_first(cap_a),
    .cap_second(cap_b), .cap_parity_ok(par_ok), .cap_valid(cap_valid));
  adcdmx_link_properties i_adcdmx_link_properties (.ref_clk(ref_clk),
    .rst_b(rst_b), .first_port_word(link.first_port_word),
    .second_port_word(link.second_port_word),
    .first_port_parity(link.first_port_parity),
    .second_port_parity(link.second_port_parity),
    .shared_output_strobe(link.shared_output_strobe),
    .resync_low(link.resync_low), .serial_load_low(link.serial_load_low),
    .serial_shift_clk(link.serial_shift_clk));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // New sample every falling edge
  always @(negedge ref_clk) sample_in <= rst_b ? sample_in + 12'h001 : 12'h000;
  task automatic chk(input string what, input logic [11:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  // Wait for the next strobe toggle, n counts cycles
  task automatic get_upd;
    logic s;
    s = link.shared_output_strobe;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (n < 20 && link.shared_output_strobe === s);
    wa = link.first_port_word;
    wb = link.second_port_word;
  endtask : get_upd
  task automatic t_mode(input logic d);
    pin = d;
    repeat (12) @(negedge ref_clk);
    chk("ratio", {11'h000, d}, {11'h000, dual_mode});
    get_upd();
    a0 = wa;
    get_upd();
    chk("strobe period", d ? 12'h002 : 12'h001, 12'(n));
    chk("first step", a0 + (d ? 12'h002 : 12'h001), wa);
    chk("first parity", {11'h000, ^wa},
      {11'h000, link.first_port_parity});
    if (d) chk("second word", wa + 12'h001, wb);
    for (int i = 0; i < 8 && cap_valid !== 1'b1; i++) @(negedge ref_clk);
    chk("capture parity", 12'h001, {11'h000, par_ok});
    if (d) chk("captured second", cap_a + 12'h001, cap_b);
  endtask : t_mode
  task automatic t_resync;
    rsy = 1'b1;
    repeat (8) @(negedge ref_clk);
    wa = link.first_port_word;
    repeat (4) @(negedge ref_clk);
    chk("resync strobe", 12'h000,
      {11'h000, link.shared_output_strobe});
    chk("resync word", wa, link.first_port_word);
    rsy = 1'b0;
    get_upd();
    get_upd();
    chk("restart", 12'h002, 12'(n));
  endtask : t_resync
  task automatic t_serial;
    pin = 1'b1;
    ser_en = 1'b1;
    cfg_frame = {4'h1, 16'h0000};
    repeat (4) @(negedge ref_clk);
    cfg_start = 1'b1;
    @(negedge ref_clk);
    cfg_start = 1'b0;
    for (int i = 0; i < 200 && cfg_busy !== 1'b0; i++) @(negedge ref_clk);
    repeat (12) @(negedge ref_clk);
    chk("serial ratio", 12'h000, {11'h000, dual_mode});
    ser_rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    ser_rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk("serial default", 12'h001, {11'h000, dual_mode});
    ser_en = 1'b0;
    pin = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk("pin ratio", 12'h000, {11'h000, dual_mode});
  endtask : t_serial
  task automatic print_verdict;
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    {rst_b, rsy, ser_en, ser_rst, cfg_start, pin} = 6'h00;
    clk_en = 1'b1;
    cfg_frame = 20'h0_0000;
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (20) @(negedge ref_clk);
    t_mode(1'b0);
    t_mode(1'b1);
    t_resync();
    t_serial();
    print_verdict();
  end
  // Watchdog
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule : adc_demux_output_and_serial_port_tb
